/* File: hw/fpm_pkg.sv */
package fpm_pkg;

	// Clock rate and the printed times; cycle counts derive from these.
	localparam int FPM_CLK_HZ = 25000000;
	localparam int FPM_SHORT_MS = 10;
	localparam int FPM_LONG_MS = 500;
	localparam int FPM_EXT_MS = 10;
	localparam int FPM_POLL_US = 1;
	localparam logic [7:0] FPM_POLL_CYC = 8'(FPM_CLK_HZ / 1000000 * FPM_POLL_US);
	localparam int FPM_TMR_W = 24;

	// Register byte offsets.
	localparam logic [7:0] FPM_RATE_OFS = 8'h00;
	localparam logic [7:0] FPM_CMD_OFS = 8'h04;
	localparam logic [7:0] FPM_CFG_OFS = 8'h08;
	localparam logic [7:0] FPM_DOR_OFS = 8'h0c;
	localparam logic [7:0] FPM_MSR_OFS = 8'h10;
	localparam logic [7:0] FPM_FIFO_OFS = 8'h14;
	localparam logic [7:0] FPM_DIR_OFS = 8'h18;
	localparam logic [7:0] FPM_STAT_OFS = 8'h1c;

	// Field positions.
	localparam int FPM_RATE_LSB = 0;
	localparam int FPM_RATE_OSC_BIT = 5;
	localparam int FPM_RATE_SLEEP_BIT = 6;
	localparam int FPM_RATE_SWRST_BIT = 7;
	localparam int FPM_CMD_AUTO_BIT = 0;
	localparam int FPM_CMD_MIN_BIT = 1;
	localparam int FPM_CMD_ALT_BIT = 2;
	localparam int FPM_CFG_ALTMODE_BIT = 0;
	localparam int FPM_CFG_LOCK_BIT = 1;
	localparam int FPM_CFG_IDLE_MASK_BIT_BIT = 2;
	localparam int FPM_DOR_RESETN_BIT = 2;
	localparam int FPM_DOR_MOTOR_LSB = 4;
	localparam int FPM_DIR_MASK_BIT = 4;
	localparam int FPM_DIR_PD_BIT = 5;
	localparam int FPM_DIR_IDLE_BIT = 6;

	// Values and reset values.
	localparam logic [7:0] FPM_MSR_IDLE = 8'h80;
	localparam logic [1:0] FPM_RATE_2M = 2'h3;
	localparam logic [1:0] FPM_RATE_RST = 2'h0;
	localparam logic [3:0] FPM_MOTOR_RST = 4'h0;

	typedef enum logic [1:0] {FPM_AWAKE, FPM_AUTO_SLEEP_ENABLE, FPM_DIRECT_PD} fpm_state_e;

	// Status that the rest of the controller presents to the sequencer.
	typedef struct packed {
		logic [7:0] mainStatus;
		logic intOut;
		logic headUnloaded;
	} fpm_core_s;

	// Steps of the reset sequence handed to the rest of the controller.
	typedef struct packed {
		logic driveInit;
		logic fifoModeReset;
		logic pollInt;
	} fpm_seq_s;

endpackage

/* File: hw/fpm_power_seq.sv */
// How it works
// - Oscillator runs while the oscillator-off bit is low, stops while high.
// - Direct powerdown does not stop the oscillator.
// - While powered down, no clock input is needed; output can gate external clock.
// - Writing one to sleep-now bit 6 enters direct powerdown at once, losing status.
// - Direct powerdown ends only on hardware or software reset.
// - Direct powerdown overrides auto powerdown and returns defaults.
// - Software reset keeps auto powerdown setup; hardware reset disables it.
// - Reset wake initialises drives, resets FIFO mode unless locked, then polls.
// - Auto powerdown needs motors off, status 80H, interrupt low, head unloaded, timer out.
// - Powerdown command enables auto sleep and picks minimum awake time.
// - Countdown starts when the command enables auto powerdown.
// - Every software reset reloads the countdown.
// - Rate change during countdown lengthens it by up to 10 ms.
// - Disabling auto powerdown cancels timers and keeps the device awake.
// - Idle maskable; alternate mode shows powered-down, idle, mask in input register; here only when the command's alternate bit is also set.
// - Access wake keeps all state; reset wake runs the reset sequence.
// - Motor bit set, status read or FIFO access wakes; output register read does not.
// - Wake reloads 10 ms or 0.5 s, halved at 2 Mbps.
// - Oscillator-off is bit 5 of the rate select register.
// - Hardware reset disables the command; software reset leaves it.
// - Idle high only at status 80H, head unloaded, interrupt low; low in direct powerdown.
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
module fpm_power_seq #(
	parameter logic [fpm_pkg::FPM_TMR_W-1:0] SHORT_CYC = 24'(fpm_pkg::FPM_CLK_HZ / 1000 * fpm_pkg::FPM_SHORT_MS),
	parameter logic [fpm_pkg::FPM_TMR_W-1:0] LONG_CYC = 24'(fpm_pkg::FPM_CLK_HZ / 1000 * fpm_pkg::FPM_LONG_MS),
	parameter logic [fpm_pkg::FPM_TMR_W-1:0] EXT_CYC = 24'(fpm_pkg::FPM_CLK_HZ / 1000 * fpm_pkg::FPM_EXT_MS)
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Controller core.
	input wire fpm_pkg::fpm_core_s coreIn,
	input wire logic [7:0] fifoRdData,
	output fpm_pkg::fpm_seq_s seqOut,
	// Power pins.
	output logic oscEnable,
	output logic poweredDownOut,
	output logic idleOut,
	output logic [3:0] motorOnOutputs
);
	import fpm_pkg::*;

	logic acc;
	logic wrPend_q;
	logic [7:0] wrAddr_q;
	logic wrRate, wrCmd, wrCfg, wrDor;
	logic rdMsr, fifoAcc, wakeAcc, swRst, sleepReq, rateChg;
	logic [1:0] rate_q;
	logic [3:0] motor_q;
	logic autoEn_q, minSel_q, altEn_q;
	logic altMode_q, lock_q, idleMask_q;
	fpm_state_e state_q, state_d;
	logic [FPM_TMR_W-1:0] timerCnt_q, loadVal;
	logic timerArmed_q, timerStart, timerCancel, autoEnter, loadSel;
	logic [FPM_TMR_W:0] extSum;
	logic [7:0] seqCnt_q;
	logic hwBoot_q, seqBusy, idle_d;
	logic [31:0] rdData;
	logic [7:0] ofs;

	// Address phase is taken when the slave is selected with a non-idle transfer.
	assign acc = hsel & htrans[1] & hready;
	assign ofs = haddr[7:0];

	// Writes complete in the data phase, so only the address is kept here.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end
		else
		begin
			wrPend_q <= acc & hwrite;
			if (acc)
				wrAddr_q <= ofs;
		end
	end

	// Write strobes and wake events.
	assign wrRate = wrPend_q && (wrAddr_q == FPM_RATE_OFS);
	assign wrCmd = wrPend_q && (wrAddr_q == FPM_CMD_OFS);
	assign wrCfg = wrPend_q && (wrAddr_q == FPM_CFG_OFS);
	assign wrDor = wrPend_q && (wrAddr_q == FPM_DOR_OFS);
	assign rdMsr = acc && !hwrite && (ofs == FPM_MSR_OFS);
	assign fifoAcc = acc && (ofs == FPM_FIFO_OFS);
	assign wakeAcc = rdMsr | fifoAcc | (wrDor && (hwdata[FPM_DOR_MOTOR_LSB +: 4] != 4'h0));
	assign swRst = (wrRate && hwdata[FPM_RATE_SWRST_BIT]) | (wrDor && !hwdata[FPM_DOR_RESETN_BIT]);
	// A reset in the same write beats a sleep request, so the part never sleeps with a reset lost.
	assign sleepReq = wrRate && hwdata[FPM_RATE_SLEEP_BIT] && !swRst;
	assign rateChg = wrRate && (hwdata[FPM_RATE_LSB +: 2] != rate_q);

	// Oscillator control is separate from every powerdown path.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			oscEnable <= 1'b1;
		else if (wrRate)
			oscEnable <= !hwdata[FPM_RATE_OSC_BIT];
	end

	// Data rate is lost on sleep and software reset.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rate_q <= FPM_RATE_RST;
		else if (swRst || sleepReq || state_q == FPM_DIRECT_PD)
			rate_q <= FPM_RATE_RST;
		else if (wrRate)
			rate_q <= hwdata[FPM_RATE_LSB +: 2];
	end

	// Motor bits; writes are dropped during direct powerdown so the outputs stay off.
	for (genvar gi = 0; gi < 4; gi++)
	begin : g_motor
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
				motor_q[gi] <= FPM_MOTOR_RST[gi];
			else if (swRst || sleepReq)
				motor_q[gi] <= 1'b0;
			else if (wrDor && state_q != FPM_DIRECT_PD)
				motor_q[gi] <= hwdata[FPM_DOR_MOTOR_LSB + gi];
		end
	end
	assign motorOnOutputs = motor_q;

	// Powerdown command survives software reset and sleep; only the pin reset clears it.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			autoEn_q <= 1'b0;
			minSel_q <= 1'b0;
			altEn_q <= 1'b0;
		end
		else if (wrCmd)
		begin
			autoEn_q <= hwdata[FPM_CMD_AUTO_BIT];
			minSel_q <= hwdata[FPM_CMD_MIN_BIT];
			altEn_q <= hwdata[FPM_CMD_ALT_BIT];
		end
	end

	// Configuration: alternate system mode, FIFO lock and idle mask.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			altMode_q <= 1'b0;
			lock_q <= 1'b0;
			idleMask_q <= 1'b0;
		end
		else if (wrCfg)
		begin
			altMode_q <= hwdata[FPM_CFG_ALTMODE_BIT];
			lock_q <= hwdata[FPM_CFG_LOCK_BIT];
			idleMask_q <= hwdata[FPM_CFG_IDLE_MASK_BIT_BIT];
		end
	end

	// Auto entry needs every idle condition at once and no reset sequence in flight.
	assign autoEnter = autoEn_q && timerArmed_q && (timerCnt_q == '0) && (motor_q == 4'h0)
		&& (coreIn.mainStatus == FPM_MSR_IDLE) && !coreIn.intOut && coreIn.headUnloaded
		&& !seqBusy && !wakeAcc && !swRst && !wrCmd;

	// Power state machine.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			FPM_AWAKE:
			begin
				if (sleepReq)
					state_d = FPM_DIRECT_PD;
				else if (autoEnter)
					state_d = FPM_AUTO_SLEEP_ENABLE;
			end
			FPM_AUTO_SLEEP_ENABLE:
			begin
				if (sleepReq)
					state_d = FPM_DIRECT_PD;
				else if (swRst || wakeAcc || (wrCmd && !hwdata[FPM_CMD_AUTO_BIT]))
					state_d = FPM_AWAKE;
			end
			FPM_DIRECT_PD:
			begin
				if (swRst)
					state_d = FPM_AWAKE;
			end
			default:
				state_d = FPM_AWAKE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= FPM_AWAKE;
		else
			state_q <= state_d;
	end

	// Reload value picks the short or long minimum awake time, halved at the top rate.
	assign loadSel = wrCmd ? hwdata[FPM_CMD_MIN_BIT] : minSel_q;
	always_comb
	begin
		loadVal = loadSel ? LONG_CYC : SHORT_CYC;
		if (rate_q == FPM_RATE_2M)
			loadVal = loadVal >> 1;
	end

	assign timerCancel = wrCmd && !hwdata[FPM_CMD_AUTO_BIT];
	assign timerStart = (wrCmd && hwdata[FPM_CMD_AUTO_BIT])
		|| (swRst && autoEn_q)
		|| (state_q == FPM_AUTO_SLEEP_ENABLE && wakeAcc);
	assign extSum = {1'b0, timerCnt_q} + {1'b0, EXT_CYC};

	// Countdown; it saturates rather than wrap when stretched near its top.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			timerCnt_q <= '0;
			timerArmed_q <= 1'b0;
		end
		else if (timerCancel || sleepReq || (!autoEn_q && !timerStart))
		begin
			timerCnt_q <= '0;
			timerArmed_q <= 1'b0;
		end
		else if (timerStart)
		begin
			timerCnt_q <= loadVal;
			timerArmed_q <= 1'b1;
		end
		else if (rateChg && timerCnt_q != '0)
			timerCnt_q <= extSum[FPM_TMR_W] ? '1 : extSum[FPM_TMR_W-1:0];
		else if (timerCnt_q != '0)
			timerCnt_q <= timerCnt_q - 1'b1;
	end

	// Reset sequence after the pin reset or a software reset.
	assign seqBusy = seqCnt_q != 8'h00;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hwBoot_q <= 1'b1;
			seqCnt_q <= 8'h00;
			seqOut <= '0;
		end
		else
		begin
			hwBoot_q <= 1'b0;
			seqOut.driveInit <= hwBoot_q || swRst;
			seqOut.fifoModeReset <= hwBoot_q || (swRst && !lock_q);
			seqOut.pollInt <= seqCnt_q == 8'h01;
			if (hwBoot_q || swRst)
				seqCnt_q <= FPM_POLL_CYC;
			else if (seqBusy)
				seqCnt_q <= seqCnt_q - 8'h01;
		end
	end

	// Idle needs a quiet core in every state but direct powerdown, so a late interrupt also drops it.
	always_comb
	begin
		idle_d = 1'b0;
		if (state_d != FPM_DIRECT_PD)
			idle_d = !idleMask_q && (coreIn.mainStatus == FPM_MSR_IDLE) && coreIn.headUnloaded
				&& !coreIn.intOut;
	end

	// While powered down only the bus decode and wake logic stay live, so the clock may stop.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			poweredDownOut <= 1'b0;
			idleOut <= 1'b0;
		end
		else
		begin
			poweredDownOut <= state_d != FPM_AWAKE;
			idleOut <= idle_d;
		end
	end

	// Read mux; the data is registered in the address phase for a zero-wait answer.
	always_comb
	begin
		rdData = 32'h0000_0000;
		if (ofs == FPM_RATE_OFS)
		begin
			rdData[FPM_RATE_LSB +: 2] = rate_q;
			rdData[FPM_RATE_OSC_BIT] = !oscEnable;
			rdData[FPM_RATE_SLEEP_BIT] = state_q == FPM_DIRECT_PD;
		end
		else if (ofs == FPM_CMD_OFS)
			rdData[2:0] = {altEn_q, minSel_q, autoEn_q};
		else if (ofs == FPM_CFG_OFS)
			rdData[2:0] = {idleMask_q, lock_q, altMode_q};
		else if (ofs == FPM_DOR_OFS)
		begin
			rdData[FPM_DOR_MOTOR_LSB +: 4] = motor_q;
			rdData[FPM_DOR_RESETN_BIT] = 1'b1;
		end
		else if (ofs == FPM_MSR_OFS)
			rdData[7:0] = coreIn.mainStatus;
		else if (ofs == FPM_FIFO_OFS)
			rdData[7:0] = fifoRdData;
		else if (ofs == FPM_DIR_OFS)
		begin
			if (altMode_q && altEn_q)
			begin
				rdData[FPM_DIR_IDLE_BIT] = idleOut;
				rdData[FPM_DIR_PD_BIT] = poweredDownOut;
				rdData[FPM_DIR_MASK_BIT] = idleMask_q;
			end
		end
		else if (ofs == FPM_STAT_OFS)
			rdData[4:0] = {timerArmed_q, seqBusy, timerArmed_q && timerCnt_q == '0,
				state_q == FPM_DIRECT_PD, poweredDownOut};
	end

	// Bus answer: always ready, always OKAY; unmapped reads return zero.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (acc && !hwrite)
				hrdata <= rdData;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_resetSteps;
		seqOut.driveInit ##[1:30] seqOut.pollInt;
	endsequence

	a_osc_follow: assert property (wrRate |=> oscEnable == !$past(hwdata[FPM_RATE_OSC_BIT]))
		else $error("oscillator enable does not follow the off bit");
	a_osc_sleep_keep: assert property (sleepReq && !hwdata[FPM_RATE_OSC_BIT] |=> oscEnable)
		else $error("direct powerdown stopped the oscillator");
	a_sleep_now: assert property (sleepReq |=> poweredDownOut && !idleOut && motor_q == 4'h0)
		else $error("sleep request did not power down at once");
	a_direct_hold: assert property (state_q == FPM_DIRECT_PD && !swRst |=> state_q == FPM_DIRECT_PD)
		else $error("direct powerdown left without reset");
	a_direct_override: assert property (state_q == FPM_AUTO_SLEEP_ENABLE && sleepReq
		|=> state_q == FPM_DIRECT_PD && timerCnt_q == '0)
		else $error("direct powerdown did not override auto powerdown");
	a_swrst_keep_cmd: assert property (swRst |=> autoEn_q == $past(autoEn_q))
		else $error("software reset changed the powerdown command");
	a_reset_steps: assert property (swRst |=> s_resetSteps)
		else $error("reset sequence steps missing");
	a_auto_entry: assert property ((state_q == FPM_AWAKE ##1 state_q == FPM_AUTO_SLEEP_ENABLE)
		|-> $past(coreIn.mainStatus) == FPM_MSR_IDLE && !$past(coreIn.intOut)
		&& $past(motor_q) == 4'h0 && $past(coreIn.headUnloaded))
		else $error("auto powerdown entered without idle conditions");
	a_timer_start: assert property (wrCmd && hwdata[FPM_CMD_AUTO_BIT] |=> timerArmed_q && timerCnt_q != '0)
		else $error("countdown did not start on enable");
	a_disable_cancel: assert property (timerCancel |=> state_q != FPM_AUTO_SLEEP_ENABLE && !timerArmed_q)
		else $error("disable did not cancel auto powerdown");
	a_wake_access: assert property (state_q == FPM_AUTO_SLEEP_ENABLE && wakeAcc && !sleepReq
		|=> state_q == FPM_AWAKE && timerCnt_q != '0 && !poweredDownOut)
		else $error("qualifying access did not wake the part");
	a_idle_direct: assert property (state_q == FPM_DIRECT_PD |-> !idleOut)
		else $error("idle high during direct powerdown");

endmodule // fpm_power_seq

/* File: verification/fpm_host_model.sv */
`timescale 1ns/1ns
module fpm_host_model (
	// Bus clock.
	input wire logic clk,
	// Slave answer.
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Master request.
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// Bus idle at time zero; only whole words are ever sent.
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One single transfer; each phase holds until hready is seen high, and released data is inverted.
	task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, ofs};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? wd : ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		hwdata <= ~hwdata;
	endtask
endmodule // fpm_host_model

/* File: verification/fpm_power_seq_test.sv */
`timescale 1ns/1ns
module fpm_power_seq_test;
	import fpm_pkg::*;
	logic clk, arst_n, hsel, hwrite, hreadyout, hresp, oscEnable, poweredDownOut, idleOut;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] motorOnOutputs;
	logic [7:0] fifoRdData;
	logic [31:0] haddr, hwdata, hrdata, rdData;
	fpm_core_s core;
	fpm_seq_s seqOut;
	int nErrors, samplesChecked, n;
	int nDrv = 0;
	int nFifo = 0;

	// Short timer values keep the run brief; expectations below use 40, 100 and 20.
	fpm_power_seq #(.SHORT_CYC(24'd40), .LONG_CYC(24'd100), .EXT_CYC(24'd20)) u_fpm_power_seq (
		.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .coreIn(core), .fifoRdData(fifoRdData), .seqOut(seqOut), .oscEnable(oscEnable),
		.poweredDownOut(poweredDownOut), .idleOut(idleOut), .motorOnOutputs(motorOnOutputs));
	fpm_host_model u_fpm_host_model (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// The clock never stops, so it is stable whenever the powered-down output is low.
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Counts reset-sequence pulses so that scenarios can compare before and after.
	always @(posedge clk)
	begin
		nDrv <= nDrv + int'(seqOut.driveInit);
		nFifo <= nFifo + int'(seqOut.fifoModeReset);
	end

	task automatic chk(input logic ok, input string msg);
		samplesChecked++;
		if (ok !== 1'b1)
		begin
			nErrors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	// Counts cycles until the powered-down output rises; 150 means it never did.
	task automatic wait_pd();
		n = 0;
		while (poweredDownOut !== 1'b1 && n < 150)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	function automatic bit near(input int e);
		return n >= e - 4 && n <= e + 4;
	endfunction

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		u_fpm_host_model.xfer(1'b1, ofs, d, rdData);
		@(negedge clk);
	endtask

	task automatic rd(input logic [7:0] ofs);
		u_fpm_host_model.xfer(1'b0, ofs, 32'h0, rdData);
		@(negedge clk);
	endtask

	task automatic set_core(input logic [7:0] m, input logic i, input logic h);
		@(posedge clk);
		core <= '{m, i, h};
	endtask

	// Hardware reset for three cycles, then the sequence of drive init and a delayed poll.
	task automatic hw_reset();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk(oscEnable === 1'b1 && poweredDownOut === 1'b0 && motorOnOutputs === 4'h0, "reset values");
		@(negedge clk);
		chk(seqOut.driveInit === 1'b1 && seqOut.fifoModeReset === 1'b1, "reset start");
		n = 0;
		while (seqOut.pollInt !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk(n == 25, "poll delay");
	endtask

	// Direct sleep keeps the oscillator and ignores motor writes; the oscillator is on before the wake.
	task automatic t_direct();
		hw_reset();
		wr(FPM_RATE_OFS, 32'h20);
		chk(oscEnable === 1'b0, "osc off");
		wr(FPM_RATE_OFS, 32'h40);
		chk(oscEnable === 1'b1 && poweredDownOut === 1'b1 && idleOut === 1'b0, "direct sleep");
		wr(FPM_DOR_OFS, 32'h14);
		rd(FPM_MSR_OFS);
		chk(poweredDownOut === 1'b1 && motorOnOutputs === 4'h0, "woke by access");
		wr(FPM_CFG_OFS, 32'h2);
		n = nFifo;
		wr(FPM_RATE_OFS, 32'h80);
		repeat (3) @(negedge clk);
		chk(poweredDownOut === 1'b0 && nFifo == n, "locked reset wake");
	endtask

	// Auto sleep entry, the wake accesses and the blocking motor.
	task automatic t_auto();
		hw_reset();
		wr(FPM_CMD_OFS, 32'h1);
		wait_pd();
		chk(near(40) && idleOut === 1'b1, "short entry");
		rd(FPM_DOR_OFS);
		chk(poweredDownOut === 1'b1, "output read woke");
		rd(FPM_MSR_OFS);
		chk(poweredDownOut === 1'b0 && rdData === 32'h80, "status read wake");
		wait_pd();
		chk(near(40), "reload on wake");
		wr(FPM_FIFO_OFS, 32'h0);
		chk(poweredDownOut === 1'b0, "fifo wake");
		wait_pd();
		rd(FPM_FIFO_OFS);
		chk(poweredDownOut === 1'b0 && rdData === 32'h5a && hresp === 1'b0, "fifo read wake");
		wait_pd();
		wr(FPM_DOR_OFS, 32'h14);
		chk(poweredDownOut === 1'b0 && motorOnOutputs === 4'h1, "motor wake");
		wr(FPM_CMD_OFS, 32'h3);
		wait_pd();
		chk(n == 150, "slept with motor on");
		wr(FPM_CMD_OFS, 32'h3);
		wr(FPM_DOR_OFS, 32'h4);
		wait_pd();
		chk(near(97), "long entry");
	endtask

	// Each busy core condition (interrupt, loaded head, status) alone holds the part awake.
	task automatic t_cond();
		hw_reset();
		wr(FPM_CMD_OFS, 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			set_core(i == 2 ? 8'h90 : 8'h80, i == 0, i != 1);
			rd(FPM_MSR_OFS);
			wait_pd();
			chk(n == 150, "slept while busy");
			set_core(8'h80, 1'b0, 1'b1);
			wait_pd();
			chk(n <= 4, "no sleep once idle");
		end
	endtask

	// Top rate halves the wake time; a rate change mid-count extends it; disabling cancels.
	task automatic t_rate();
		hw_reset();
		wr(FPM_RATE_OFS, 32'h3);
		wr(FPM_CMD_OFS, 32'h1);
		wait_pd();
		rd(FPM_MSR_OFS);
		wait_pd();
		chk(near(20), "halved wake");
		hw_reset();
		wr(FPM_CMD_OFS, 32'h1);
		wr(FPM_RATE_OFS, 32'h1);
		wait_pd();
		chk(near(57), "rate extends");
		rd(FPM_MSR_OFS);
		wr(FPM_CMD_OFS, 32'h0);
		wait_pd();
		chk(n == 150, "slept when disabled");
	endtask

	// Direct sleep over auto sleep; software reset keeps the setup, hardware reset drops it.
	task automatic t_reset_wake();
		hw_reset();
		wr(FPM_CMD_OFS, 32'h1);
		wait_pd();
		wr(FPM_RATE_OFS, 32'h40);
		rd(FPM_STAT_OFS);
		chk(rdData[1] === 1'b1 && idleOut === 1'b0, "direct over auto");
		n = nDrv;
		wr(FPM_DOR_OFS, 32'h0);
		repeat (3) @(negedge clk);
		chk(poweredDownOut === 1'b0 && nDrv == n + 1, "soft reset wake");
		wait_pd();
		chk(near(37), "setup kept");
		hw_reset();
		wait_pd();
		chk(n == 150, "auto after hard reset");
	endtask

	// Idle pin, its mask, and the alternate-mode input register.
	task automatic t_idle();
		hw_reset();
		wr(FPM_CFG_OFS, 32'h1);
		rd(FPM_DIR_OFS);
		chk(rdData === 32'h0, "input register flags shown without enable");
		wr(FPM_CMD_OFS, 32'h4);
		rd(FPM_DIR_OFS);
		chk(idleOut === 1'b1 && rdData === 32'h40, "idle shown");
		wr(FPM_CFG_OFS, 32'h5);
		rd(FPM_DIR_OFS);
		chk(idleOut === 1'b0 && rdData === 32'h10, "idle masked");
		wr(FPM_CFG_OFS, 32'h1);
		set_core(8'h80, 1'b1, 1'b1);
		repeat (3) @(negedge clk);
		chk(idleOut === 1'b0, "idle with interrupt");
		set_core(8'h80, 1'b0, 1'b1);
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// The scenarios need about 2000 cycles; ten times that cuts a hang short.
	initial
	begin
		#800000;
		nErrors++;
		$display("mismatch at %0t: watchdog expired", $time);
		report_and_stop();
	end

	// Main sequence.
	initial
	begin
		arst_n = 1'b0;
		core = '{8'h80, 1'b0, 1'b1};
		fifoRdData = 8'h5a;
		nErrors = 0;
		samplesChecked = 0;
		t_direct();
		t_auto();
		t_cond();
		t_rate();
		t_reset_wake();
		t_idle();
		report_and_stop();
	end
endmodule // fpm_power_seq_test
